// File: logic/dcc_channel_path.sv
`include "dcc_defines.svh"

// What this block does
// - bank bit 0 stores channel data in input A, 1 in input B
// - one global bank bit serves all channels, no per-channel choice
// - each channel holds inputs A/B, gain, offset, calibrated A/B, converter
// - input A through multiply-add into calibrated A, B likewise into B
// - a single multiply-add unit is shared by all channels
// - input, gain or offset writes recompute calibrated reg of the bank
// - calibrated and converter registers have no host read or write path
// - two 4-bit select registers, 0 picks calibrated A, 1 picks B
// - a global command sets all select bits to 0 or all to 1
// - load strobe low updates all eight converter registers together
// - load held low passes new calibrated data straight to converters
// - two 14-bit group offset codes, channels 0-3 and 4-7
// - group offset codes reset to 0x2000
// - 16-bit resets: input 0x8000, gain 0xffff, offset 0x8000
// - 16-bit code = in*(gain+1)/2^16 + offset - 2^15, range 0..65535
// - 16-bit variant subtracts group offset times 4
// - 14-bit resets: input 0x2000, gain 0x3fff, offset 0x2000
// - 14-bit code = in*(gain+1)/2^14 + offset - 2^13, range 0..16383
// - control register holds the bank bit at bit 2
module dcc_channel_path
    import dcc_pkg::*;
#(
    parameter bit WIDE16 = 1'b1
) (
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    input  wire logic                          wr_valid,
    input  wire dcc_write_s                    wr_req,
    output logic                               wr_ready,
    input  wire logic                          load_outputs_n,
    output logic [`DCC_CTRL_W-1:0]             control_out,
    output logic [`DCC_OFS_W-1:0]              group0_offset_code,
    output logic [`DCC_OFS_W-1:0]              group1_offset_code,
    output logic [`DCC_CHANNELS-1:0]           select_out,
    output logic [`DCC_CHANNELS-1:0][15:0]     dac_code,
    output logic [`DCC_CHANNELS-1:0][17:0]     dac_net_code,
    output logic                               calc_busy
);

    // ------------------------------------------------------------
    // variant constants
    // ------------------------------------------------------------
    localparam dcc_code_t INPUT_RST = WIDE16 ? `DCC_W16_INPUT_RST
                                             : `DCC_W14_INPUT_RST;
    localparam dcc_code_t GAIN_RST  = WIDE16 ? `DCC_W16_GAIN_RST
                                             : `DCC_W14_GAIN_RST;
    localparam dcc_code_t OFFS_RST  = WIDE16 ? `DCC_W16_OFFS_RST
                                             : `DCC_W14_OFFS_RST;
    localparam dcc_code_t CODE_MAX  = WIDE16 ? `DCC_W16_MAX
                                             : `DCC_W14_MAX;
    localparam int        SHIFT     = WIDE16 ? `DCC_W16_SHIFT
                                             : `DCC_W14_SHIFT;
    localparam int        OFS_SCALE = WIDE16 ? `DCC_W16_OFS_SCALE
                                             : `DCC_W14_OFS_SCALE;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    dcc_code_t                     input_reg_a    [`DCC_CHANNELS];
    dcc_code_t                     input_reg_b    [`DCC_CHANNELS];
    dcc_code_t                     gain_reg       [`DCC_CHANNELS];
    dcc_code_t                     offs_reg       [`DCC_CHANNELS];
    dcc_code_t                     calibrated_reg_a [`DCC_CHANNELS];
    dcc_code_t                     calibrated_reg_b [`DCC_CHANNELS];
    logic [`DCC_CTRL_W-1:0]        control_reg;
    logic [`DCC_OFS_W-1:0]         group_ofs_reg  [2];
    logic [`DCC_CHANNELS-1:0]      select_reg;
    dcc_job_s                      queue_mem      [`DCC_QUEUE_DEPTH];
    logic [`DCC_QUEUE_AW-1:0]      wr_ptr_reg;
    logic [`DCC_QUEUE_AW-1:0]      rd_ptr_reg;
    logic [`DCC_QUEUE_AW:0]        count_reg;
    logic [`DCC_QUEUE_AW:0]        count_next;
    logic [2:0]                    load_sync_reg;
    logic                          load_low_reg;
    logic                          bank_bit;
    logic                          accept;
    logic                          push;
    logic                          pop;
    dcc_job_s                      head;
    dcc_code_t                     wr_data_masked;
    dcc_code_t                     cal_result;

    assign bank_bit = control_reg[`DCC_CTRL_BANK_SEL];
    assign accept   = wr_valid && wr_ready;
    assign push     = accept && (wr_req.target == DCC_WR_INPUT
                              || wr_req.target == DCC_WR_GAIN
                              || wr_req.target == DCC_WR_OFFSET);
    assign pop      = count_reg != '0;
    assign head     = queue_mem[rd_ptr_reg];
    assign wr_data_masked = wr_req.data & CODE_MAX;

    // ------------------------------------------------------------
    // shared multiply-add with saturation
    // ------------------------------------------------------------
    function automatic dcc_code_t calibrate(
        input dcc_code_t in_code,
        input dcc_code_t gain,
        input dcc_code_t offs
    );
        logic [33:0]        product;
        logic signed [35:0] sum;
        product = {18'h0, in_code} * ({18'h0, gain} + 34'h1);
        sum = $signed({2'b00, product >> SHIFT})
            + $signed({20'h0, offs})
            - $signed({20'h0, (OFFS_RST & CODE_MAX)});
        if (sum < 36'sd0) begin
            calibrate = '0;
        end else if (sum > $signed({20'h0, CODE_MAX})) begin
            calibrate = CODE_MAX;
        end else begin
            calibrate = sum[15:0];
        end
    endfunction : calibrate

    // one unit, fed from the queue head only
    assign cal_result = calibrate(head.bank ? input_reg_b[head.channel]
                                            : input_reg_a[head.channel],
                                  gain_reg[head.channel],
                                  offs_reg[head.channel]);

    // ------------------------------------------------------------
    // host-visible registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            control_reg <= `DCC_CTRL_RST;
        end else if (accept && wr_req.target == DCC_WR_CONTROL) begin
            control_reg <= wr_req.data[`DCC_CTRL_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            group_ofs_reg[0] <= `DCC_GROUP_OFS_RST;
            group_ofs_reg[1] <= `DCC_GROUP_OFS_RST;
        end else if (accept && wr_req.target == DCC_WR_GROUP_OFS) begin
            group_ofs_reg[wr_req.channel[0]] <=
                wr_req.data[`DCC_OFS_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            select_reg <= {2{`DCC_SELECT_RST}};
        end else if (accept && wr_req.target == DCC_WR_SELECT_ALL) begin
            select_reg <= {`DCC_CHANNELS{wr_req.data[0]}};
        end else if (accept && wr_req.target == DCC_WR_SELECT) begin
            if (wr_req.channel[0]) begin
                select_reg[7:4] <= wr_req.data[3:0];
            end else begin
                select_reg[3:0] <= wr_req.data[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // per-channel input and trim registers
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `DCC_CHANNELS; ch++) begin : g_chan
            logic hit;
            assign hit = accept && wr_req.channel == 3'(ch);

            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    input_reg_a[ch] <= INPUT_RST;
                    input_reg_b[ch] <= INPUT_RST;
                    gain_reg[ch]    <= GAIN_RST;
                    offs_reg[ch]    <= OFFS_RST;
                end else if (hit) begin
                    if (wr_req.target == DCC_WR_INPUT && !bank_bit) begin
                        input_reg_a[ch] <= wr_data_masked;
                    end
                    if (wr_req.target == DCC_WR_INPUT && bank_bit) begin
                        input_reg_b[ch] <= wr_data_masked;
                    end
                    if (wr_req.target == DCC_WR_GAIN) begin
                        gain_reg[ch] <= wr_data_masked;
                    end
                    if (wr_req.target == DCC_WR_OFFSET) begin
                        offs_reg[ch] <= wr_data_masked;
                    end
                end
            end

            // ----------------------------------------------------
            // calibrated registers: written only by the shared unit
            // ----------------------------------------------------
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    calibrated_reg_a[ch] <= INPUT_RST;
                    calibrated_reg_b[ch] <= INPUT_RST;
                end else if (pop && head.channel == 3'(ch)) begin
                    if (head.bank) begin
                        calibrated_reg_b[ch] <= cal_result;
                    end else begin
                        calibrated_reg_a[ch] <= cal_result;
                    end
                end
            end

            // ----------------------------------------------------
            // converter register, no host path to it
            // ----------------------------------------------------
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    dac_code[ch] <= INPUT_RST;
                end else if (load_low_reg) begin
                    dac_code[ch] <= select_reg[ch] ? calibrated_reg_b[ch]
                                                  : calibrated_reg_a[ch];
                end
            end

            // ----------------------------------------------------
            // net code after group offset
            // ----------------------------------------------------
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    dac_net_code[ch] <= '0;
                end else begin
                    dac_net_code[ch] <= 18'({2'b00, dac_code[ch]})
                        - 18'({4'h0, group_ofs_reg[ch / `DCC_GROUP_SIZE]}
                              << OFS_SCALE);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // recalculation queue, arrival order
    // ------------------------------------------------------------
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            queue_mem[wr_ptr_reg] <= '{channel: wr_req.channel,
                                       bank:    bank_bit};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ready <= 1'b0;
        end else begin
            wr_ready <= count_next < (`DCC_QUEUE_AW+1)'(`DCC_QUEUE_DEPTH - 1);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            calc_busy <= 1'b0;
        end else begin
            calc_busy <= count_next != '0;
        end
    end

    // ------------------------------------------------------------
    // load strobe synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            load_sync_reg <= 3'h7;
            load_low_reg  <= 1'b0;
        end else begin
            load_sync_reg <= {load_sync_reg[1:0], load_outputs_n};
            if (load_sync_reg[1] == load_sync_reg[2]) begin
                load_low_reg <= !load_sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            control_out <= `DCC_CTRL_RST;
        end else begin
            control_out <= control_reg;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            group0_offset_code <= `DCC_GROUP_OFS_RST;
        end else begin
            group0_offset_code <= group_ofs_reg[0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            group1_offset_code <= `DCC_GROUP_OFS_RST;
        end else begin
            group1_offset_code <= group_ofs_reg[1];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            select_out <= {2{`DCC_SELECT_RST}};
        end else begin
            select_out <= select_reg;
        end
    end

endmodule : dcc_channel_path

// File: logic/dcc_defines.svh
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DCC_CHANNELS        8
`define DCC_GROUP_SIZE      4
`define DCC_CODE_W          16
`define DCC_OFS_W           14
`define DCC_CTRL_W          5
`define DCC_QUEUE_DEPTH     16
`define DCC_QUEUE_AW        4

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define DCC_CTRL_POWER_DOWN 0
`define DCC_CTRL_THERM_SD   1
`define DCC_CTRL_BANK_SEL   2
`define DCC_CTRL_CHECK_ERR  3
`define DCC_CTRL_OVERTEMP   4

// ----------------------------------------------------------------
// reset values and scaling, 16-bit variant
// ----------------------------------------------------------------
`define DCC_W16_INPUT_RST   16'h8000
`define DCC_W16_GAIN_RST    16'hffff
`define DCC_W16_OFFS_RST    16'h8000
`define DCC_W16_MAX         16'hffff
`define DCC_W16_SHIFT       16
`define DCC_W16_OFS_SCALE   2

// ----------------------------------------------------------------
// reset values and scaling, 14-bit variant
// ----------------------------------------------------------------
`define DCC_W14_INPUT_RST   16'h2000
`define DCC_W14_GAIN_RST    16'h3fff
`define DCC_W14_OFFS_RST    16'h2000
`define DCC_W14_MAX         16'h3fff
`define DCC_W14_SHIFT       14
`define DCC_W14_OFS_SCALE   0

// ----------------------------------------------------------------
// shared reset values
// ----------------------------------------------------------------
`define DCC_GROUP_OFS_RST   14'h2000
`define DCC_CTRL_RST        5'h00
`define DCC_SELECT_RST      4'h0

`endif

// File: logic/dcc_pkg.sv
`include "dcc_defines.svh"

package dcc_pkg;

    // ------------------------------------------------------------
    // host write targets
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DCC_WR_INPUT      = 3'h0,
        DCC_WR_GAIN       = 3'h1,
        DCC_WR_OFFSET     = 3'h2,
        DCC_WR_GROUP_OFS  = 3'h3,
        DCC_WR_SELECT     = 3'h4,
        DCC_WR_SELECT_ALL = 3'h5,
        DCC_WR_CONTROL    = 3'h6
    } dcc_target_e;

    typedef logic [`DCC_CODE_W-1:0] dcc_code_t;

    typedef struct packed {
        dcc_target_e              target;
        logic [2:0]               channel;
        logic [`DCC_CODE_W-1:0]   data;
    } dcc_write_s;

    typedef struct packed {
        logic [2:0] channel;
        logic       bank;
    } dcc_job_s;

endpackage : dcc_pkg

// File: verif/dcc_channel_path_monitor.sv
module dcc_channel_path_monitor
    import dcc_pkg::*;
(
    input wire logic             mclk,
    input wire logic             reset_n,
    input wire logic             wr_valid,
    input wire dcc_write_s       wr_req,
    input wire logic             wr_ready,
    input wire logic             load_outputs_n,
    input wire logic [4:0]       control_out,
    input wire logic [13:0]      group0_offset_code,
    input wire logic [13:0]      group1_offset_code,
    input wire logic [7:0]       select_out,
    input wire logic [7:0][15:0] dac_code,
    input wire logic [7:0][17:0] dac_net_code,
    input wire logic             calc_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence taken(dcc_target_e t);
        wr_valid && wr_ready && wr_req.target == t;
    endsequence
    sequence load_idle;
        load_outputs_n [*6];
    endsequence
    ctrl_store_a:
        assert property (taken(DCC_WR_CONTROL) |-> ##2
        control_out == $past(wr_req.data[4:0], 2)) else $error("bad control");
    select_all_a:
        assert property (taken(DCC_WR_SELECT_ALL) |-> ##2
        select_out == {8{$past(wr_req.data[0], 2)}}) else $error("bad fill");
    select_group_a:
        assert property (taken(DCC_WR_SELECT) ##0 wr_req.channel[0] |-> ##2
        select_out[7:4] == $past(wr_req.data[3:0], 2)) else $error("bad sel");
    group_ofs_a:
        assert property (taken(DCC_WR_GROUP_OFS) ##0 !wr_req.channel[0] |->
        ##2 group0_offset_code == $past(wr_req.data[13:0], 2))
        else $error("bad group offset");
    load_hold_a:
        assert property (load_idle |=> $stable(dac_code))
        else $error("converter moved while load high");
    net_code_a:
        assert property (dac_net_code[4] == {2'b00, $past(dac_code[4])}
        - {2'b00, group1_offset_code, 2'b00}) else $error("bad net");
    recalc_start_a:
        assert property (wr_valid && wr_ready && wr_req.target inside
        {DCC_WR_INPUT, DCC_WR_GAIN, DCC_WR_OFFSET} |=> calc_busy)
        else $error("no recalculation");
    busy_bound_a:
        assert property ($rose(calc_busy) |-> ##[1:40] !calc_busy)
        else $error("recalculation stuck");
    reset_vals_a:
        assert property ($rose(reset_n) |-> group0_offset_code == 14'h2000
        && group1_offset_code == 14'h2000 && select_out == 8'h00)
        else $error("bad reset values");
    ready_reset_a:
        assert property ($rose(reset_n) |=> wr_ready)
        else $error("not ready after reset");
endmodule : dcc_channel_path_monitor

bind dcc_channel_path dcc_channel_path_monitor dcc_channel_path_monitor_inst (
    .mclk(mclk), .reset_n(reset_n), .wr_valid(wr_valid), .wr_req(wr_req),
    .wr_ready(wr_ready), .load_outputs_n(load_outputs_n),
    .control_out(control_out), .group0_offset_code(group0_offset_code),
    .group1_offset_code(group1_offset_code), .select_out(select_out),
    .dac_code(dac_code), .dac_net_code(dac_net_code), .calc_busy(calc_busy));

// File: verif/dcc_host_model.sv
module dcc_host_model
    import dcc_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  wr_ready,
    output dcc_write_s wr_req,
    output logic       wr_valid,
    output logic       load_outputs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_valid = 1'b0;
        wr_req = '0;
        load_outputs_n = 1'b1;
    end
    // write held until taken or 200 cycles pass, then data scrambled
    task automatic write(dcc_target_e t, logic [2:0] c, logic [15:0] d);
        int w;
        w = 0;
        if (t == DCC_WR_GROUP_OFS && d > 16'h2000) d = 16'h2000;
        @(posedge mclk);
        wr_valid <= 1'b1;
        wr_req <= '{t, c, d};
        do begin
            @(posedge mclk);
            w++;
        end while (wr_ready !== 1'b1 && w < 200);
        wr_valid <= 1'b0;
        wr_req.data <= ~d;
    endtask : write
    task automatic set_load(logic v);
        @(posedge mclk);
        load_outputs_n <= v;
    endtask : set_load
endmodule : dcc_host_model

// File: verif/tb_top.sv
module tb_top
    import dcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int kind; int idx; logic [17:0] exp;} dcc_note_s;
    logic mclk, reset_n, wr_valid, wr_ready, load_outputs_n, calc_busy;
    dcc_write_s       wr_req;
    logic [4:0]       control_out, ctrl;
    logic [13:0]      group0_offset_code, group1_offset_code, gofs[2];
    logic [7:0]       select_out, sel;
    logic [7:0][15:0] dac_code;
    logic [7:0][17:0] dac_net_code;
    logic [15:0]      in_a[8], in_b[8], gn[8], of[8], cal_a[8], cal_b[8];
    logic [15:0]      dac_m[8];
    dcc_note_s        notes[$];
    event             settled;
    int               n_mismatch = 0;
    int               tests_run = 0;
    string kn[5] = '{"dac_code", "dac_net_code", "select", "control", "gofs"};

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    dcc_channel_path #(.WIDE16(1'b1)) dcc_channel_path_inst (
        .mclk(mclk), .reset_n(reset_n), .wr_valid(wr_valid),
        .wr_req(wr_req), .wr_ready(wr_ready), .load_outputs_n(load_outputs_n),
        .control_out(control_out), .group0_offset_code(group0_offset_code),
        .group1_offset_code(group1_offset_code), .select_out(select_out),
        .dac_code(dac_code), .dac_net_code(dac_net_code),
        .calc_busy(calc_busy));
    dcc_host_model dcc_host_model_inst (.mclk(mclk), .wr_ready(wr_ready),
        .wr_req(wr_req), .wr_valid(wr_valid),
        .load_outputs_n(load_outputs_n));

    function automatic logic [15:0] calc(logic [15:0] x, g, o);
        longint v;
        v = ((longint'(x) * (longint'(g) + 1)) >>> 16) + longint'(o) - 32768;
        return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : v[15:0];
    endfunction : calc
    task automatic wr(dcc_target_e t, logic [2:0] c, logic [15:0] d);
        logic b;
        b = ctrl[2];
        dcc_host_model_inst.write(t, c, d);
        case (t)
            DCC_WR_INPUT: begin
                if (b) in_b[c] = d;
                else in_a[c] = d;
            end
            DCC_WR_GAIN: gn[c] = d;
            DCC_WR_OFFSET: of[c] = d;
            DCC_WR_GROUP_OFS: gofs[c[0]] = d[13:0];
            DCC_WR_SELECT: sel[c[0]*4 +: 4] = d[3:0];
            DCC_WR_SELECT_ALL: sel = {8{d[0]}};
            DCC_WR_CONTROL: ctrl = d[4:0];
            default: ;
        endcase
        if (t <= DCC_WR_OFFSET && b) cal_b[c] = calc(in_b[c], gn[c], of[c]);
        if (t <= DCC_WR_OFFSET && !b) cal_a[c] = calc(in_a[c], gn[c], of[c]);
    endtask : wr
    task automatic expect_all(logic loaded);
        int w;
        w = 0;
        while (calc_busy !== 1'b0 && w < 100) begin
            @(posedge mclk);
            w++;
        end
        repeat (8) @(posedge mclk);
        for (int c = 0; c < 8; c++) begin
            if (loaded) dac_m[c] = sel[c] ? cal_b[c] : cal_a[c];
            notes.push_back('{0, c, {2'b00, dac_m[c]}});
            notes.push_back('{1, c, {2'b00, dac_m[c]}
                - {2'b00, gofs[c/4], 2'b00}});
        end
        notes.push_back('{2, 0, {10'h0, sel}});
        notes.push_back('{3, 0, {13'h0, ctrl}});
        notes.push_back('{4, 0, {4'h0, gofs[0]}});
        notes.push_back('{4, 1, {4'h0, gofs[1]}});
        -> settled;
        @(posedge mclk);
    endtask : expect_all
    task automatic check_val(string nm, int i, logic [17:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s[%0d] expected %h seen %h", nm, i, e, g);
        end
    endtask : check_val
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    initial forever begin
        dcc_note_s n;
        logic [17:0] g;
        @(settled);
        while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.kind)
                0: g = {2'b00, dac_code[n.idx]};
                1: g = dac_net_code[n.idx];
                2: g = {10'h0, select_out};
                3: g = {13'h0, control_out};
                default: g = {4'h0, n.idx ? group1_offset_code
                    : group0_offset_code};
            endcase
            check_val(kn[n.kind], n.idx, n.exp, g);
        end
    end
    initial begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        int r;
        reset_n = 1'b0;
        for (int c = 0; c < 8; c++) begin
            in_a[c] = 16'h8000;
            in_b[c] = 16'h8000;
            gn[c] = 16'hffff;
            of[c] = 16'h8000;
            cal_a[c] = 16'h8000;
            cal_b[c] = 16'h8000;
            dac_m[c] = 16'h8000;
        end
        sel = 8'h00;
        ctrl = 5'h00;
        gofs = '{14'h2000, 14'h2000};
        r = $urandom(65901);
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        expect_all(1'b0);
        $display("test reset values done");
        for (int c = 0; c < 8; c++) wr(DCC_WR_INPUT, 3'(c), 16'($urandom));
        expect_all(1'b0);
        dcc_host_model_inst.set_load(1'b0);
        expect_all(1'b1);
        dcc_host_model_inst.set_load(1'b1);
        $display("test load strobe done");
        dcc_host_model_inst.set_load(1'b0);
        for (int k = 0; k < 60; k++) begin
            dcc_target_e t;
            logic [15:0] d;
            t = dcc_target_e'(3'($urandom_range(6)));
            d = (t == DCC_WR_GROUP_OFS) ? 16'($urandom_range(8192))
                : 16'($urandom);
            wr(t, 3'($urandom_range(7)), d);
            if (k % 4 == 3) expect_all(1'b1);
        end
        $display("test random traffic done");
        for (int v = 0; v < 2; v++) begin
            wr(DCC_WR_SELECT_ALL, 3'h0, 16'(v));
            wr(DCC_WR_CONTROL, 3'h0, 16'(v * 4));
            wr(DCC_WR_GAIN, 3'h7, 16'hffff);
            wr(DCC_WR_OFFSET, 3'h7, v ? 16'hffff : 16'h0000);
            wr(DCC_WR_INPUT, 3'h7, v ? 16'hffff : 16'h0000);
            expect_all(1'b1);
        end
        $display("test saturation done");
        stop_test();
    end
endmodule : tb_top
